// [logic/spi_status_flags.sv]
// Function
// - receive element count at bits 28..24, enhanced mode only; reads zero in legacy mode
// - transmit element count at bits 20..16, enhanced mode only; reads zero in legacy mode
// - frame error flag set on framing error
// - activity flag high while transaction runs
// - underrun flag set when a framed sync finds the transmit shifter empty
// - underrun cleared by off-on or write zero
// - bit 7 shows shift register empty
// - overflow flag set, new word discarded
// - overflow set by hardware, cleared like underrun
// - rx empty when read equals write pointer
// - unimplemented status bits read zero
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module spi_status_flags
  import spi_status_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // serial link, slave side
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_sel_n,
  output logic o_sdo,
  // interrupt
  output logic o_irq
);

  // occupied elements between two pointers
  function automatic logic [`PTR_W-1:0] fill(
    input logic [`PTR_W-1:0] wp,
    input logic [`PTR_W-1:0] rp
  );
    fill = wp - rp;
  endfunction

  // decode used by the setup phase to flag unmapped addresses
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFS_CONTROL) || (a == `OFS_STATUS) ||
             (a == `OFS_DATA) || (a == `OFS_IRQ_STATUS) ||
             (a == `OFS_IRQ_MASK);
  endfunction

  state_t q;
  state_t d;
  logic [`SYNC_W-1:0] pins_s;  // synced sck, sdi, select
  logic sck_s;
  logic sdi_s;
  logic sel_n_s;

  // pins come from the partner's clock domain; select enters inverted
  // so the cleared synchroniser reads as deselected, not as a false select
  link_sync #(
    .W(`SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async({i_sck, i_sdi, ~i_sel_n}),
    .o_sync(pins_s)
  );

  assign sck_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign sel_n_s = !pins_s[0];

  // working values of the combinational step
  logic [`PTR_W-1:0] cap;       // words each buffer may hold
  logic [`PTR_W-1:0] rx_cnt;
  logic [`PTR_W-1:0] tx_cnt;
  logic rise;                   // sck rising, sample sdi
  logic fall;                   // sck falling, move sdo
  logic setup;                  // apb setup cycle
  logic access;                 // apb completing edge
  logic word_start;             // first bit of a word
  logic word_done;              // eighth bit sampled
  logic active;
  logic [31:0] status;
  logic [`WORD_W-1:0] rx_word;

  always_comb begin
    d = q;
    cap = q.enh ? `CAP_ENH : `CAP_LEGACY;
    rx_cnt = fill(q.rx_wp, q.rx_rp);
    tx_cnt = fill(q.tx_wp, q.tx_rp);
    rise = sck_s && !q.sck_prev;
    fall = !sck_s && q.sck_prev;
    setup = i_psel && !i_penable;
    access = i_psel && i_penable && q.pready;
    d.sck_prev = sck_s;
    word_start = 1'b0;
    word_done = 1'b0;
    rx_word = {q.rx_sh[`WORD_W-2:0], sdi_s};

    // a word is in flight, or in unframed mode the partner holds the select; off is idle
    active = q.on && ((q.bitcnt != 3'h0) || (!q.frm && !sel_n_s));

    // status image; every bit not assigned stays zero
    status = '0;
    if (q.enh) begin
      status[`ST_RX_CNT_HI:`ST_RX_CNT_LO] = rx_cnt;
      status[`ST_TX_CNT_HI:`ST_TX_CNT_LO] = tx_cnt;
    end
    status[`ST_FRAME_ERR] = q.ferr;
    status[`ST_ACTIVE] = active;
    status[`ST_TX_UNDERRUN] = q.tur;
    status[`ST_SHIFTER_EMPTY] = !q.sh_full;
    status[`ST_RX_OVERFLOW] = q.rov;
    status[`ST_RX_EMPTY] = (q.rx_rp == q.rx_wp);
    status[`ST_TX_EMPTY] = (tx_cnt == '0);
    status[`ST_TX_FULL] = (tx_cnt == cap);
    status[`ST_RX_FULL] = (rx_cnt == cap);

    // apb setup: answer is prepared so pready rises one edge later
    if (setup) begin
      d.pready = 1'b1;
      d.pslverr = !mapped(i_paddr);
      d.prdata = '0;
      if (!i_pwrite) begin
        unique case (i_paddr)
          `OFS_CONTROL: begin
            d.prdata[`CTL_ON] = q.on;
            d.prdata[`CTL_ENH] = q.enh;
            d.prdata[`CTL_FRM] = q.frm;
          end
          `OFS_STATUS: begin
            d.prdata = status;
          end
          `OFS_DATA: begin
            // reading pops; an empty buffer returns zero
            if (rx_cnt != '0) begin
              d.prdata[`WORD_W-1:0] = q.rxm[q.rx_rp[3:0]];
              d.rx_rp = q.rx_rp + 5'h01;
            end
          end
          `OFS_IRQ_STATUS: begin
            d.prdata[`IRQ_BITS-1:0] = q.ist;
          end
          `OFS_IRQ_MASK: begin
            d.prdata[`IRQ_BITS-1:0] = q.imask;
          end
          default: begin
            d.prdata = '0;
          end
        endcase
      end
    end

    // apb access: writes land only on the completing edge
    if (access) begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (i_pwrite) begin
        unique case (i_paddr)
          `OFS_CONTROL: begin
            d.on = i_pwdata[`CTL_ON];
            d.enh = i_pwdata[`CTL_ENH];
            d.frm = i_pwdata[`CTL_FRM];
          end
          `OFS_STATUS: begin
            // writing a zero clears; writing a one leaves the flag
            if (!i_pwdata[`ST_TX_UNDERRUN]) begin
              d.tur = 1'b0;
            end
            if (!i_pwdata[`ST_RX_OVERFLOW]) begin
              d.rov = 1'b0;
            end
            if (!i_pwdata[`ST_FRAME_ERR]) begin
              d.ferr = 1'b0;
            end
          end
          `OFS_DATA: begin
            // a write into a full buffer is dropped
            if (tx_cnt != cap) begin
              d.txm[q.tx_wp[3:0]] = i_pwdata[`WORD_W-1:0];
              d.tx_wp = q.tx_wp + 5'h01;
            end
          end
          `OFS_IRQ_STATUS: begin
            d.ist = q.ist & ~i_pwdata[`IRQ_BITS-1:0];
          end
          `OFS_IRQ_MASK: begin
            d.imask = i_pwdata[`IRQ_BITS-1:0];
          end
          default: begin
            d.ist = d.ist;
          end
        endcase
      end
    end

    // link: mode 0 slave, msb first, sample on rise, shift on fall
    if (q.on) begin
      if (!q.frm && sel_n_s) begin
        // deselect abandons any partial word
        d.bitcnt = 3'h0;
      end else if (rise) begin
        if (q.frm && !sel_n_s) begin
          // sync pulse mid-word means the frame is broken
          if (q.bitcnt != 3'h0) begin
            d.ferr = 1'b1;
            d.ist[`IRQ_FRAME_ERR] = 1'b1;
          end
          word_start = 1'b1;
        end else if (!q.frm && q.bitcnt == 3'h0) begin
          word_start = 1'b1;
        end
        if (word_start || q.bitcnt != 3'h0) begin
          d.rx_sh = rx_word;
          d.bitcnt = word_start ? 3'h1 : q.bitcnt + 3'h1;
          word_done = !word_start && (q.bitcnt == `LAST_BIT);
        end
        // framed sync found no word waiting in the shifter
        if (word_start && q.frm && !q.sh_full) begin
          d.tur = 1'b1;
          d.ist[`IRQ_TX_UNDERRUN] = 1'b1;
        end
      end else if (fall && q.bitcnt != 3'h0) begin
        d.tx_sh = {q.tx_sh[`WORD_W-2:0], 1'b0};
      end

      if (word_done) begin
        // the unread word is kept and the new one thrown away
        if (fill(q.rx_wp, d.rx_rp) == cap) begin
          d.rov = 1'b1;
          d.ist[`IRQ_RX_OVERFLOW] = 1'b1;
        end else begin
          d.rxm[q.rx_wp[3:0]] = rx_word;
          d.rx_wp = q.rx_wp + 5'h01;
          d.ist[`IRQ_RX_WORD] = 1'b1;
        end
        d.sh_full = 1'b0;
        d.tx_sh = '0;
      end

      // refill the shifter between words so sdo is set up early
      if (!d.sh_full && d.bitcnt == 3'h0 &&
          fill(d.tx_wp, q.tx_rp) != '0) begin
        d.tx_sh = d.txm[q.tx_rp[3:0]];
        d.tx_rp = q.tx_rp + 5'h01;
        d.sh_full = 1'b1;
      end
    end else begin
      // module off: buffers, link and error flags return to rest
      d.rx_wp = '0;
      d.rx_rp = '0;
      d.tx_wp = '0;
      d.tx_rp = '0;
      d.bitcnt = 3'h0;
      d.sh_full = 1'b0;
      d.tx_sh = '0;
      d.rov = 1'b0;
      d.tur = 1'b0;
      d.ferr = 1'b0;
    end

    // outputs are registered copies of the next state
    d.sdo = d.tx_sh[`WORD_W-1];
    d.irq = |(d.ist & d.imask);
  end

  // single register bank; reset loads constants only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_sdo = q.sdo;
  assign o_irq = q.irq;

endmodule

// [logic/spi_status_defs.svh]
`ifndef SPI_STATUS_DEFS_SVH
`define SPI_STATUS_DEFS_SVH

// register byte offsets on the apb window
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_DATA 12'h008
`define OFS_IRQ_STATUS 12'h00c
`define OFS_IRQ_MASK 12'h010

// control register fields
`define CTL_ON 15
`define CTL_ENH 0
`define CTL_FRM 1

// serial_port_status fields
`define ST_RX_CNT_HI 28
`define ST_RX_CNT_LO 24
`define ST_TX_CNT_HI 20
`define ST_TX_CNT_LO 16
`define ST_FRAME_ERR 12
`define ST_ACTIVE 11
`define ST_TX_UNDERRUN 8
`define ST_SHIFTER_EMPTY 7
`define ST_RX_OVERFLOW 6
`define ST_RX_EMPTY 5
`define ST_TX_EMPTY 3
`define ST_TX_FULL 1
`define ST_RX_FULL 0

// interrupt status and mask fields
`define IRQ_RX_WORD 0
`define IRQ_RX_OVERFLOW 1
`define IRQ_TX_UNDERRUN 2
`define IRQ_FRAME_ERR 3
`define IRQ_BITS 4

// buffer geometry: enhanced mode holds 16 words, legacy mode one
`define FIFO_DEPTH 16
`define PTR_W 5
`define WORD_W 8
`define CAP_ENH 5'h10
`define CAP_LEGACY 5'h01
`define LAST_BIT 3'h7

// synchroniser width: sck, sdi, select
`define SYNC_W 3

`endif

// [logic/spi_status_pkg.sv]
package spi_status_pkg;
`include "spi_status_defs.svh"

  // whole state of the serial unit, registered in one place
  typedef struct packed {
    logic on;                                  // module on
    logic enh;                                 // enhanced_buffer_select
    logic frm;                                 // framed_mode_select
    logic [`FIFO_DEPTH-1:0][`WORD_W-1:0] rxm;  // receive storage
    logic [`PTR_W-1:0] rx_wp;                  // fifo_write_pointer
    logic [`PTR_W-1:0] rx_rp;                  // fifo_read_pointer
    logic [`FIFO_DEPTH-1:0][`WORD_W-1:0] txm;  // transmit storage
    logic [`PTR_W-1:0] tx_wp;
    logic [`PTR_W-1:0] tx_rp;
    logic [`WORD_W-1:0] rx_sh;                 // receive shifter
    logic [`WORD_W-1:0] tx_sh;                 // transmit shifter
    logic [2:0] bitcnt;                        // bits of current word
    logic sh_full;                             // tx shifter loaded
    logic sck_prev;                            // last synced sck
    logic rov;                                 // rx_overflow_flag
    logic tur;                                 // tx_underrun_flag
    logic ferr;                                // frame_error_flag
    logic [`IRQ_BITS-1:0] ist;                 // sticky events
    logic [`IRQ_BITS-1:0] imask;               // event enables
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic sdo;
  } state_t;

endpackage

// [logic/link_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser for the asynchronous link pins
module link_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;  // first stage, read only by the second
    logic [W-1:0] sync;  // second stage, safe to use
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  // next state: plain shift through both stages
  always_comb begin
    d.meta = i_async;
    d.sync = q.meta;
  end

  // registers: constants only under reset
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.sync;

endmodule

// [testbench/spi_status_flags_properties.sv]
`timescale 1ns/1ps
`include "spi_status_defs.svh"
module spi_status_checker (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // setup phase of a transfer
  logic setup;
  assign setup = i_psel && !i_penable;
  a_ready_next: assert property (setup |=> o_pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_ready_idle: assert property (!i_psel |=> !o_pready)
    else $error("ready without select");
  a_err_ready: assert property (o_pslverr |-> o_pready && o_prdata == 0)
    else $error("error without ready or with data");
  a_err_unmapped: assert property (setup && i_paddr > `OFS_IRQ_MASK
    |=> o_pslverr)
    else $error("unmapped address accepted");
  a_err_mapped: assert property (setup && i_paddr[1:0] == 2'h0 &&
    i_paddr <= `OFS_IRQ_MASK |=> !o_pslverr)
    else $error("mapped address refused");
  // the reserved holes of the status word, except bit 2, always read back zero
  a_resv_zero: assert property (setup && !i_pwrite &&
    i_paddr == `OFS_STATUS |=> (o_prdata & 32'he0e0e610) == 0)
    else $error("reserved status bit set");
  a_count_range: assert property (setup && !i_pwrite &&
    i_paddr == `OFS_STATUS |=> o_prdata[28:24] <= 5'h10 &&
    o_prdata[20:16] <= 5'h10)
    else $error("element count beyond depth");
  a_mask_quiet: assert property (i_psel && i_penable && o_pready &&
    i_pwrite && i_paddr == `OFS_IRQ_MASK && i_pwdata == 0
    |-> ##[1:3] !o_irq)
    else $error("irq stays with all masked");
  c_err: cover property (o_pslverr);
  c_irq: cover property ($rose(o_irq));
  c_stat: cover property (setup && i_paddr == `OFS_STATUS);
endmodule
bind spi_status_flags spi_status_checker chk (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_irq(o_irq));

// [testbench/spi_link_master.sv]
`timescale 1ns/1ps
// far-side master: sck stands low outside frames
module spi_link_master (
  output logic o_sck,
  output logic o_sdi,
  output logic o_sel_n,
  input wire logic i_sdo
);
  logic [7:0] got; // word seen on the return line
  initial begin
    o_sck = 0;
    o_sdi = 0;
    o_sel_n = 1;
  end
  // n bits msb first; framed pulses sync for the first bit only
  task xfer(input logic [7:0] b, input int n, input bit framed);
    o_sel_n = 0;
    for (int i = 0; i < n; i++) begin
      o_sdi = b[7-i];
      #80 o_sck = 1;
      got = {got[6:0], i_sdo};
      #80 o_sck = 0;
      if (framed) o_sel_n = 1;
    end
    o_sel_n = 1;
    o_sdi = ~o_sdi; // released line: no stale level
    #80; // idle gap so the deselect is synced before anyone looks
  endtask
endmodule

// [testbench/spi_status_flags_tb.sv]
`timescale 1ns/1ps
`include "spi_status_defs.svh"
module spi_status_flags_tb;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sck, sdi, sel_n, sdo, irq, er;
  int fails = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  spi_status_flags uut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sck(sck), .i_sdi(sdi), .i_sel_n(sel_n),
    .o_sdo(sdo), .o_irq(irq));
  spi_link_master m (.o_sck(sck), .o_sdi(sdi), .o_sel_n(sel_n),
    .i_sdo(sdo));
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; waits for ready, only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_reset;
    apb(0, `OFS_STATUS, 0);
    check("status", rd, 32'h000000a8);
    apb(0, 12'h020, 0);
    check("unmapped", {er, rd[30:0]}, 32'h80000000);
  endtask
  // enhanced: counts, fifo order, irq raise and clear
  task t_enh;
    apb(1, `OFS_CONTROL, 32'h8001);
    apb(1, `OFS_IRQ_MASK, 32'h1);
    apb(1, `OFS_DATA, 32'ha5);
    apb(1, `OFS_DATA, 32'h3c);
    apb(1, `OFS_DATA, 32'h5a);
    m.xfer(8'hc3, 8, 0);
    apb(0, `OFS_STATUS, 0);
    check("enh status", rd, 32'h01010000);
    check("tx word", m.got, 32'ha5);
    check("irq on", irq, 1);
    m.xfer(8'h96, 8, 0);
    check("tx word", m.got, 32'h3c);
    apb(0, `OFS_DATA, 0);
    check("rx first", rd, 32'hc3);
    apb(0, `OFS_DATA, 0);
    check("rx second", rd, 32'h96);
    apb(0, `OFS_STATUS, 0);
    check("drained", rd, 32'h00000028);
    apb(1, `OFS_IRQ_STATUS, 32'h1);
    apb(0, `OFS_IRQ_STATUS, 0);
    check("irq off", {irq, rd[3:0]}, 32'h0);
  endtask
  // single-word mode: second word overflows and is lost
  task t_ovf;
    apb(1, `OFS_CONTROL, 32'h8000);
    m.xfer(8'h11, 8, 0);
    m.xfer(8'h22, 8, 0);
    apb(0, `OFS_STATUS, 0);
    check("ovf status", rd, 32'h000000c9);
    apb(0, `OFS_DATA, 0);
    check("kept word", rd, 32'h11);
    apb(1, `OFS_STATUS, 32'h0);
    apb(0, `OFS_STATUS, 0);
    check("ovf clear", rd, 32'h000000a8);
  endtask
  // framed: underrun, short frame, then off-on clears all
  task t_frame;
    apb(1, `OFS_CONTROL, 32'h8002);
    m.xfer(8'h77, 8, 1);
    m.xfer(8'h00, 4, 1);
    apb(0, `OFS_STATUS, 0);
    check("partial word", rd, 32'h00000989);
    m.xfer(8'h00, 8, 1);
    apb(0, `OFS_STATUS, 0);
    check("frame status", rd, 32'h000011c9);
    apb(1, `OFS_STATUS, 32'h00001040);
    apb(0, `OFS_STATUS, 0);
    check("tur clear", rd, 32'h000010c9);
    apb(1, `OFS_CONTROL, 32'h0);
    apb(1, `OFS_CONTROL, 32'h8002);
    apb(0, `OFS_STATUS, 0);
    check("off on", rd, 32'h000000a8);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    t_reset;
    t_enh;
    t_ovf;
    t_frame;
    wrap_up;
  end
  // whole run is about 9.3 us; a hang ends at 100 us
  initial begin
    #100us;
    fails++;
    wrap_up;
  end
endmodule
